// ===== design/acs_pkg.sv
// Contract
// - Read-only 8-bit identification register holds a fixed firmware revision code.
// - Error bits are sticky; hardware never clears them; software writes zeros.
// - Error bit D7 sets when master clocks per frame period vary.
// - Error bit D5 sets when bit clocks per frame period vary.
// - Error bit D4 sets when the frame clock frequency changes.
// - Error bit D3 sets when frame clock phase drifts from internal sync.
// - D6 lock failure, D2 clipping, D1 protection faults; D0 reserved.
// - First control D7 enables the dc-blocking filter; default enabled.
// - First control D5 picks hard unmute (default) or soft unmute recovery.
// - First control D1-D0 selects de-emphasis: none, 32, 44.1, 48 kHz.
// - Format codes: right-justified 0-2, I2S 3-5, left-justified 6-8.
// - Second control D6 set keeps all outputs shut down; cleared plays.
// - Second control D7 enables the mid-level output ramp; default off.
// - Second control D3 selects the subchannel modulation scheme.
// - Second control D2 selects two bridge-tied or 2.1 output topology.
// - Second control D1 turns the address-select pin into a fault output.
package acs_pkg;

    // Register offsets on the serial control bus.
    localparam logic [7:0] ACS_OFS_ID     = 8'h01;
    localparam logic [7:0] ACS_OFS_ERR    = 8'h02;
    localparam logic [7:0] ACS_OFS_SYS1   = 8'h03;
    localparam logic [7:0] ACS_OFS_FMT    = 8'h04;
    localparam logic [7:0] ACS_OFS_SYS2   = 8'h05;

    // Error register bit positions.
    localparam int ACS_ERR_MCLK  = 7;
    localparam int ACS_ERR_PLL   = 6;
    localparam int ACS_ERR_SCLK  = 5;
    localparam int ACS_ERR_LRCLK = 4;
    localparam int ACS_ERR_SLIP  = 3;
    localparam int ACS_ERR_CLIP  = 2;
    localparam int ACS_ERR_PROT  = 1;
    localparam logic [7:0] ACS_ERR_MASK = 8'hFE;

    // First system control fields.
    localparam int ACS_S1_DCBLK  = 7;
    localparam int ACS_S1_HARDUM = 5;
    localparam int ACS_S1_DEEMH  = 1;
    localparam int ACS_S1_DEEML  = 0;
    localparam logic [7:0] ACS_S1_MASK  = 8'hA3;
    localparam logic [7:0] ACS_S1_RESET = 8'hA0;

    // Second system control fields.
    localparam int ACS_S2_MIDZ  = 7;
    localparam int ACS_S2_SHDN  = 6;
    localparam int ACS_S2_MOD   = 3;
    localparam int ACS_S2_TOPO  = 2;
    localparam int ACS_S2_ASEL  = 1;
    localparam logic [7:0] ACS_S2_MASK  = 8'hCE;
    localparam logic [7:0] ACS_S2_RESET = 8'h40;

    // Serial format codes.
    localparam logic [3:0] ACS_FMT_RESET   = 4'h5;
    localparam logic [3:0] ACS_FMT_LAST    = 4'h8;

    // Measurement widths in bits, tolerances in counts.
    localparam int ACS_EDGE_CW  = 12;
    localparam int ACS_FRAME_CW = 16;
    localparam int ACS_EDGE_TOL  = 1;
    localparam int ACS_FRAME_TOL = 1;

endpackage

// ===== design/acs_flag_if.sv
`timescale 1ns/1ns
interface acs_flag_if;
    logic [7:0] set_vec;
    logic       clr_we;
    logic [7:0] clr_data;
    logic [7:0] flags;

    modport bank
    (
        input  set_vec,
        input  clr_we,
        input  clr_data,
        output flags
    );

    modport user
    (
        output set_vec,
        output clr_we,
        output clr_data,
        input  flags
    );
endinterface

// ===== design/acs_sticky_bank.sv
`timescale 1ns/1ns
module acs_sticky_bank
    import acs_pkg::*;
(
    // Clock and reset.
    input  wire logic  core_clk_i,
    input  wire logic  rst_n_i,
    // Flag access.
    acs_flag_if.bank   flag_port
);
    typedef struct packed {
        logic [7:0] flags;
    } acs_bank_state_t;

    acs_bank_state_t state_reg;
    acs_bank_state_t state_next;

    // A write of zero clears a bit, but a new event in that cycle wins.
    always_comb
    begin
        state_next = state_reg;
        if (flag_port.clr_we)
        begin
            state_next.flags = state_reg.flags & flag_port.clr_data;
        end
        state_next.flags = (state_next.flags | flag_port.set_vec)
                           & ACS_ERR_MASK;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign flag_port.flags = state_reg.flags;
endmodule

// ===== design/acs_rate_meter.sv
`timescale 1ns/1ns
module acs_rate_meter
#(
    parameter int CW  = 12,
    parameter int TOL = 1
)
(
    // Clock and reset.
    input  wire logic          core_clk_i,
    input  wire logic          rst_n_i,
    // Events.
    input  wire logic          tick_i,
    input  wire logic          frame_i,
    // Results.
    output logic [CW-1:0]      count_o,
    output logic               changed_o
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic [CW-1:0] last;
        logic          valid;
        logic          changed;
    } acs_meter_state_t;

    acs_meter_state_t state_reg;
    acs_meter_state_t state_next;
    logic [CW-1:0]    diff;

    // Counts ticks per frame and flags a count that moved beyond tolerance.
    always_comb
    begin
        state_next = state_reg;
        state_next.changed = 1'b0;
        diff = (state_reg.cnt > state_reg.last)
             ? state_reg.cnt - state_reg.last
             : state_reg.last - state_reg.cnt;
        if (frame_i)
        begin
            if (state_reg.valid && (diff > CW'(TOL)))
            begin
                state_next.changed = 1'b1;
            end
            state_next.last  = state_reg.cnt;
            state_next.valid = 1'b1;
            state_next.cnt   = tick_i ? CW'(1) : '0;
        end
        else if (tick_i && (state_reg.cnt != '1))
        begin
            state_next.cnt = state_reg.cnt + CW'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign count_o   = state_reg.last;
    assign changed_o = state_reg.changed;
endmodule

// ===== design/acs_regs.sv
`timescale 1ns/1ns
module acs_regs
    import acs_pkg::*;
#(
    // Identification value; this value is arbitrary.
    parameter logic [7:0] ID_CODE = 8'h5A
)
(
    // Clock and reset.
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,

    // Register access from the serial control bus.
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_rd_i,
    output logic [7:0]       reg_rdata_o,
    output logic             reg_rvalid_o,

    // Audio clock pins, sampled as levels.
    input  wire logic        mclk_i,
    input  wire logic        sclk_i,
    input  wire logic        lrclk_i,

    // Fault sources.
    input  wire logic        pll_unlock_i,
    input  wire logic        clip_i,
    input  wire logic        prot_fault_i,

    // Address-select pin.
    input  wire logic        addr_sel_pin_i,
    output logic             addr_sel_pin_o,
    output logic             addr_sel_pin_oe_n_o,
    output logic             addr_sel_level_o,

    // Control outputs.
    output logic             dc_block_en_o,
    output logic             hard_unmute_o,
    output logic [1:0]       deemph_sel_o,
    output logic [3:0]       serial_format_o,
    output logic             midz_ramp_en_o,
    output logic             shutdown_o,
    output logic             modulation_scheme_second_o,
    output logic             single_ended_output_o,
    output logic             bridge_tied_output_o,
    output logic             clock_error_o
);
    typedef struct packed {
        logic                    mclk_prev;
        logic                    sclk_prev;
        logic                    lrclk_prev;
        logic [ACS_FRAME_CW-1:0] sync_cnt;
        logic                    sync_valid;
        logic                    slip;
        logic [7:0]              sys1;
        logic [3:0]              fmt;
        logic [7:0]              sys2;
        logic [7:0]              rdata;
        logic                    rvalid;
        logic                    pin_out;
        logic                    pin_level;
        logic                    clk_err;
    } acs_regs_state_t;

    acs_regs_state_t state_reg;
    acs_regs_state_t state_next;

    acs_flag_if flag_bus ();

    logic                    mclk_rise;
    logic                    sclk_rise;
    logic                    frame_start;
    logic [ACS_EDGE_CW-1:0]  mclk_count;
    logic [ACS_EDGE_CW-1:0]  sclk_count;
    logic [ACS_FRAME_CW-1:0] frame_period;
    logic                    mclk_changed;
    logic                    sclk_changed;
    logic                    frame_changed;
    logic                    wr_err;
    logic [7:0]              events;

    assign mclk_rise   = mclk_i & ~state_reg.mclk_prev;
    assign sclk_rise   = sclk_i & ~state_reg.sclk_prev;
    assign frame_start = lrclk_i & ~state_reg.lrclk_prev;

    // Master clocks per frame period.
    acs_rate_meter #(
        .CW  (ACS_EDGE_CW),
        .TOL (ACS_EDGE_TOL)
    ) u_mclk_meter (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .tick_i     (mclk_rise),
        .frame_i    (frame_start),
        .count_o    (mclk_count),
        .changed_o  (mclk_changed)
    );

    // Bit clocks per frame period.
    acs_rate_meter #(
        .CW  (ACS_EDGE_CW),
        .TOL (ACS_EDGE_TOL)
    ) u_sclk_meter (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .tick_i     (sclk_rise),
        .frame_i    (frame_start),
        .count_o    (sclk_count),
        .changed_o  (sclk_changed)
    );

    // Frame period in core clocks, which tracks the frame rate.
    acs_rate_meter #(
        .CW  (ACS_FRAME_CW),
        .TOL (ACS_FRAME_TOL)
    ) u_frame_meter (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .tick_i     (1'b1),
        .frame_i    (frame_start),
        .count_o    (frame_period),
        .changed_o  (frame_changed)
    );

    // Event vector for the sticky error register.
    always_comb
    begin
        events = '0;
        events[ACS_ERR_MCLK]  = mclk_changed;
        events[ACS_ERR_SCLK]  = sclk_changed;
        events[ACS_ERR_LRCLK] = frame_changed;
        events[ACS_ERR_SLIP]  = state_reg.slip;
        events[ACS_ERR_PLL]   = pll_unlock_i;
        events[ACS_ERR_CLIP]  = clip_i;
        events[ACS_ERR_PROT]  = prot_fault_i;
    end

    assign wr_err            = reg_wr_i && (reg_addr_i == ACS_OFS_ERR);
    assign flag_bus.set_vec  = events;
    assign flag_bus.clr_we   = wr_err;
    assign flag_bus.clr_data = reg_wdata_i;

    acs_sticky_bank u_err_bank (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .flag_port  (flag_bus.bank)
    );

    always_comb
    begin
        state_next = state_reg;
        state_next.mclk_prev  = mclk_i;
        state_next.sclk_prev  = sclk_i;
        state_next.lrclk_prev = lrclk_i;
        state_next.slip       = 1'b0;
        state_next.rvalid     = 1'b0;

        // The internal frame sync free-runs on the last measured period.
        if (state_reg.sync_cnt >= frame_period - ACS_FRAME_CW'(1))
        begin
            state_next.sync_cnt = '0;
        end
        else
        begin
            state_next.sync_cnt = state_reg.sync_cnt + ACS_FRAME_CW'(1);
        end

        // An aligned frame edge meets the sync at count zero.
        if (frame_start)
        begin
            if (state_reg.sync_valid
                && (state_reg.sync_cnt > ACS_FRAME_CW'(ACS_FRAME_TOL))
                && (state_reg.sync_cnt < frame_period
                    - ACS_FRAME_CW'(ACS_FRAME_TOL)))
            begin
                state_next.slip = 1'b1;
            end
            state_next.sync_cnt   = ACS_FRAME_CW'(1);
            state_next.sync_valid = (frame_period != '0);
        end

        // Register writes keep only defined bits.
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                ACS_OFS_SYS1:
                begin
                    state_next.sys1 = reg_wdata_i & ACS_S1_MASK;
                end
                ACS_OFS_FMT:
                begin
                    // Reserved codes are ignored and the format holds.
                    if (reg_wdata_i[3:0] <= ACS_FMT_LAST
                        && reg_wdata_i[7:4] == 4'h0)
                    begin
                        state_next.fmt = reg_wdata_i[3:0];
                    end
                end
                ACS_OFS_SYS2:
                begin
                    state_next.sys2 = reg_wdata_i & ACS_S2_MASK;
                end
                default:
                begin
                    state_next.sys1 = state_reg.sys1;
                end
            endcase
        end

        // Reads answer one cycle later; unmapped offsets read as zero.
        if (reg_rd_i)
        begin
            state_next.rvalid = 1'b1;
            case (reg_addr_i)
                ACS_OFS_ID:
                begin
                    state_next.rdata = ID_CODE;
                end
                ACS_OFS_ERR:
                begin
                    state_next.rdata = flag_bus.flags;
                end
                ACS_OFS_SYS1:
                begin
                    state_next.rdata = state_reg.sys1;
                end
                ACS_OFS_FMT:
                begin
                    state_next.rdata = {4'h0, state_reg.fmt};
                end
                ACS_OFS_SYS2:
                begin
                    state_next.rdata = state_reg.sys2;
                end
                default:
                begin
                    state_next.rdata = 8'h00;
                end
            endcase
        end

        // In the output role the pin shows the protection fault, low active.
        state_next.pin_out = ~prot_fault_i;
        if (!state_reg.sys2[ACS_S2_ASEL])
        begin
            state_next.pin_level = addr_sel_pin_i;
        end

        state_next.clk_err = mclk_changed | sclk_changed
                             | frame_changed | state_reg.slip;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_reg            <= '0;
            state_reg.sys1       <= ACS_S1_RESET;
            state_reg.fmt        <= ACS_FMT_RESET;
            state_reg.sys2       <= ACS_S2_RESET;
            state_reg.pin_out    <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Register-bus answer.
    assign reg_rdata_o  = state_reg.rdata;
    assign reg_rvalid_o = state_reg.rvalid;

    // First control register fields.
    assign dc_block_en_o = state_reg.sys1[ACS_S1_DCBLK];
    assign hard_unmute_o = state_reg.sys1[ACS_S1_HARDUM];
    assign deemph_sel_o  = state_reg.sys1[ACS_S1_DEEMH:ACS_S1_DEEML];

    // Serial word format.
    assign serial_format_o = state_reg.fmt;

    // Second control register fields.
    assign midz_ramp_en_o             = state_reg.sys2[ACS_S2_MIDZ];
    assign shutdown_o                 = state_reg.sys2[ACS_S2_SHDN];
    assign modulation_scheme_second_o = state_reg.sys2[ACS_S2_MOD];
    assign single_ended_output_o      = state_reg.sys2[ACS_S2_TOPO];
    assign bridge_tied_output_o       = ~state_reg.sys2[ACS_S2_TOPO];

    // Address-select pin role.
    assign addr_sel_pin_o      = state_reg.pin_out;
    assign addr_sel_pin_oe_n_o = ~state_reg.sys2[ACS_S2_ASEL];
    assign addr_sel_level_o    = state_reg.pin_level;

    assign clock_error_o = state_reg.clk_err;
endmodule

// ===== bench/acs_regs_assertions.sv
`timescale 1ns/1ns
module acs_regs_chk
    import acs_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h5A
)
(
    // Clock, reset and register bus.
    input wire logic       core_clk_i,
    input wire logic       rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       reg_rvalid_o,
    // Faults, pin and controls.
    input wire logic       pll_unlock_i,
    input wire logic       prot_fault_i,
    input wire logic       addr_sel_pin_o,
    input wire logic       addr_sel_pin_oe_n_o,
    input wire logic [3:0] serial_format_o,
    input wire logic       shutdown_o,
    input wire logic       single_ended_output_o,
    input wire logic       bridge_tied_output_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_id_value: assert property (
        reg_rd_i && reg_addr_i == ACS_OFS_ID
        |=> reg_rvalid_o && reg_rdata_o == ID_CODE)
        else $error("identification read wrong");
    chk_err_reserved: assert property (
        reg_rd_i && reg_addr_i == ACS_OFS_ERR |=> !reg_rdata_o[0])
        else $error("reserved error bit set");
    chk_err_sticky: assert property (
        reg_rd_i && reg_addr_i == ACS_OFS_ERR && $past(rst_n_i, 2)
        && $past(pll_unlock_i, 2) && !$past(reg_wr_i)
        |=> reg_rdata_o[ACS_ERR_PLL])
        else $error("lock error flag lost");
    chk_fmt_refuse: assert property (
        reg_wr_i && reg_addr_i == ACS_OFS_FMT && reg_wdata_i > 8'h08
        |=> $stable(serial_format_o))
        else $error("reserved format stored");
    chk_fmt_store: assert property (
        reg_wr_i && reg_addr_i == ACS_OFS_FMT && reg_wdata_i <= 8'h08
        |=> serial_format_o == $past(reg_wdata_i[3:0]))
        else $error("format not stored");
    chk_shutdown_wr: assert property (
        reg_wr_i && reg_addr_i == ACS_OFS_SYS2
        |=> shutdown_o == $past(reg_wdata_i[ACS_S2_SHDN]))
        else $error("shutdown does not follow write");
    chk_topo_pair: assert property (
        reg_wr_i && reg_addr_i == ACS_OFS_SYS2
        |=> single_ended_output_o == $past(reg_wdata_i[ACS_S2_TOPO])
        && bridge_tied_output_o != single_ended_output_o)
        else $error("topology outputs wrong");
    chk_pin_role: assert property (
        reg_wr_i && reg_addr_i == ACS_OFS_SYS2
        |=> addr_sel_pin_oe_n_o == !$past(reg_wdata_i[ACS_S2_ASEL]))
        else $error("pin direction wrong");
    chk_fault_out: assert property (
        !addr_sel_pin_oe_n_o ##1 !addr_sel_pin_oe_n_o
        |-> addr_sel_pin_o == !$past(prot_fault_i))
        else $error("fault output wrong");
endmodule

bind acs_regs acs_regs_chk #(.ID_CODE(ID_CODE)) i_acs_regs_chk (
    .core_clk_i            (core_clk_i),
    .rst_n_i               (rst_n_i),
    .reg_addr_i            (reg_addr_i),
    .reg_wr_i              (reg_wr_i),
    .reg_wdata_i           (reg_wdata_i),
    .reg_rd_i              (reg_rd_i),
    .reg_rdata_o           (reg_rdata_o),
    .reg_rvalid_o          (reg_rvalid_o),
    .pll_unlock_i          (pll_unlock_i),
    .prot_fault_i          (prot_fault_i),
    .addr_sel_pin_o        (addr_sel_pin_o),
    .addr_sel_pin_oe_n_o   (addr_sel_pin_oe_n_o),
    .serial_format_o       (serial_format_o),
    .shutdown_o            (shutdown_o),
    .single_ended_output_o (single_ended_output_o),
    .bridge_tied_output_o  (bridge_tied_output_o)
);

// ===== bench/acs_host_model.sv
`timescale 1ns/1ns
module acs_host_model
(
    // Clock.
    input  wire logic  core_clk_i,
    // Register requests.
    output logic [7:0] reg_addr_o,
    output logic       reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic       reg_rd_o
);
    initial
    begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o    = 1'b0;
    end

    // Idle address and data lines show the inverse of the last value, never a stale one.
    task automatic req(input logic w, input logic [7:0] a,
                       input logic [7:0] d, input int gap);
        repeat (gap) @(posedge core_clk_i);
        @(posedge core_clk_i);
        #1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = w;
        reg_rd_o    = !w;
        @(posedge core_clk_i);
        #1;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ns
module testbench
    import acs_pkg::*;
;
    // Arbitrary identification value.
    localparam logic [7:0] ID_VAL = 8'h3C;
    logic       clk;
    logic       rst_n;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [3:0] fmt;
    logic [1:0] de;
    logic       wr, rd, rvalid, pll, clip, prot, ext, pin_o, oe_n, lvl;
    logic       dc, hu, mz, sd, ms, se, bt, cerr;
    logic       mclk  = 1'b0;
    logic       sclk  = 1'b0;
    logic       lrclk = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] v;
    logic [3:0] ef;
    logic [2:0] f;
    int         err_count = 0;
    int         total_checks = 0;
    int         cerr_n = 0;
    int         lr_per = 64, mc_per = 2, sc_per = 4;
    int         ph = 0, lr_c = 64, m_c = 2, s_c = 4;
    int         tl[4] = '{64, 64, 96, 96};
    int         tm[4] = '{2, 4, 2, 3};
    int         ts[4] = '{8, 4, 4, 6};
    logic [7:0] te[4] = '{8'h20, 8'h80, 8'hB8, 8'h18};
    wire        pin_in = oe_n ? ext : pin_o;

    acs_regs #(.ID_CODE(ID_VAL)) i_acs_regs (
        .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .mclk_i(mclk),
        .sclk_i(sclk), .lrclk_i(lrclk), .pll_unlock_i(pll),
        .clip_i(clip), .prot_fault_i(prot), .addr_sel_pin_i(pin_in),
        .addr_sel_pin_o(pin_o), .addr_sel_pin_oe_n_o(oe_n),
        .addr_sel_level_o(lvl), .dc_block_en_o(dc),
        .hard_unmute_o(hu), .deemph_sel_o(de), .serial_format_o(fmt),
        .midz_ramp_en_o(mz), .shutdown_o(sd),
        .modulation_scheme_second_o(ms), .single_ended_output_o(se),
        .bridge_tied_output_o(bt), .clock_error_o(cerr));
    acs_host_model i_acs_host_model (.core_clk_i(clk),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
        .reg_rd_o(rd));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Audio clocks; new periods take effect at a frame boundary.
    always @(posedge clk)
    begin
        #1;
        ph = ph + 1;
        if (ph >= lr_c)
        begin
            ph   = 0;
            lr_c = lr_per;
            m_c  = mc_per;
            s_c  = sc_per;
        end
        lrclk = ph < lr_c / 2;
        mclk  = (ph % m_c) < m_c / 2;
        sclk  = (ph % s_c) < s_c / 2;
    end

    // Counts clock-error pulses so that a scenario can ask whether any came.
    always @(posedge clk)
    begin
        if (cerr === 1'b1)
            cerr_n++;
    end

    task automatic cmp(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        i_acs_host_model.req(1'b1, a, d, $urandom_range(2));
    endtask

    task automatic rdr(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_acs_host_model.req(1'b0, a, 8'h00, 0);
    endtask

    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk)
    begin
        if (rvalid === 1'b1)
        begin
            if (exp_q.size() > 0)
                cmp("read data", exp_q.pop_front(), rdata);
            else
                cmp("read count", 8'h00, 8'h01);
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        cmp("run time", 8'h00, 8'h01);
        report_and_stop();
    end

    initial
    begin
        {rst_n, pll, clip, prot, ext} = 5'b00001;
        void'($urandom(80));
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        cmp("sys1 out", 8'h0C, {4'h0, dc, hu, de});
        cmp("sys2 out", 8'h09, {3'h0, mz, sd, ms, se, bt});
        rdr(ACS_OFS_ID, ID_VAL);
        wrr(ACS_OFS_ID, 8'hFF);
        rdr(ACS_OFS_ID, ID_VAL);
        rdr(ACS_OFS_SYS1, 8'hA0);
        rdr(ACS_OFS_FMT, 8'h05);
        rdr(ACS_OFS_SYS2, 8'h40);
        rdr(8'h00, 8'h00);
        rdr(8'h07, 8'h00);
        for (int i = 0; i < 8; i++)
        begin
            v = 8'($urandom()) & ACS_S1_MASK;
            v[1:0] = i[1:0];
            wrr(ACS_OFS_SYS1, v);
            cmp("sys1", {4'h0, v[7], v[5], v[1:0]}, {4'h0, dc, hu, de});
            v = 8'($urandom()) & ACS_S2_MASK;
            wrr(ACS_OFS_SYS2, v);
            cmp("sys2", {3'h0, v[7:6], v[3:2], !v[1]},
                {3'h0, mz, sd, ms, se, oe_n});
            cmp("bridge", {7'h0, !v[2]}, {7'h0, bt});
        end
        wrr(ACS_OFS_SYS1, 8'hFF);
        rdr(ACS_OFS_SYS1, ACS_S1_MASK);
        wrr(ACS_OFS_SYS2, 8'hFF);
        rdr(ACS_OFS_SYS2, ACS_S2_MASK);
        ef = ACS_FMT_RESET;
        for (int c = 0; c < 16; c++)
        begin
            if (c <= ACS_FMT_LAST)
                ef = 4'(c);
            wrr(ACS_OFS_FMT, 8'(c));
            cmp("format", {4'h0, ef}, {4'h0, fmt});
        end
        wrr(ACS_OFS_FMT, 8'h13);
        rdr(ACS_OFS_FMT, {4'h0, ef});
        repeat (300) @(posedge clk);
        cerr_n = 0;
        for (int k = 0; k < 3; k++)
        begin
            wrr(ACS_OFS_ERR, 8'h00);
            f = 3'b100 >> k;
            {pll, clip, prot} = f;
            @(posedge clk);
            #1;
            {pll, clip, prot} = 3'b000;
            rdr(ACS_OFS_ERR, {1'b0, f[2], 3'h0, f[1:0], 1'b0});
        end
        {pll, clip, prot} = 3'b111;
        wrr(ACS_OFS_ERR, 8'h42);
        {pll, clip, prot} = 3'b000;
        wrr(ACS_OFS_ERR, 8'hFF);
        rdr(ACS_OFS_ERR, 8'h46);
        wrr(ACS_OFS_ERR, 8'h42);
        rdr(ACS_OFS_ERR, 8'h42);
        wrr(ACS_OFS_SYS2, 8'h02);
        prot = 1'b1;
        wrr(ACS_OFS_ERR, 8'h00);
        cmp("fault pin", 8'h00, {6'h0, oe_n, pin_o});
        prot = 1'b0;
        rdr(ACS_OFS_ERR, 8'h02);
        wrr(ACS_OFS_SYS2, 8'h00);
        for (int b = 0; b < 2; b++)
        begin
            ext = b[0];
            repeat (2) @(posedge clk);
            #1;
            cmp("pin level", {7'h0, b[0]}, {7'h0, lvl});
        end
        cmp("clock quiet", 8'h00, 8'(cerr_n));
        for (int t = 0; t < 4; t++)
        begin
            cerr_n = 0;
            wrr(ACS_OFS_ERR, 8'h00);
            rdr(ACS_OFS_ERR, 8'h00);
            {lr_per, mc_per, sc_per} = {tl[t], tm[t], ts[t]};
            repeat (300) @(posedge clk);
            {lr_per, mc_per, sc_per} = {32'd64, 32'd2, 32'd4};
            repeat (300) @(posedge clk);
            rdr(ACS_OFS_ERR, te[t]);
            cmp("clock error", 8'h01, {7'h0, cerr_n != 0});
        end
        repeat (4) @(posedge clk);
        cmp("reads left", 8'h00, 8'(exp_q.size()));
        report_and_stop();
    end
endmodule
